// file: verilog/rsow_writer.sv
// Purpose: Output stage of the second resizer channel: averaging, RGB packing, masking, SDRAM addressing
// Assumes: One 4:2:2 sample pair per input beat (Y, Cb or Cr alternating); output one word per pixel
// Notes:   Overview of operation
//
// Overview of operation
// - Averaging only when downscale enable is set
// - Horizontal size code doubles factor each step
// - Vertical size code uses same eight steps
// - RGB select picks YCbCr or RGB output
// - Width select picks ARGB8888 or RGB565
// - Leading mask drops first two pixels
// - Trailing mask drops last two pixels
// - Alpha register fills ARGB alpha byte
// - Base address from high and low halves
// - Start address from high and low halves
// - Line address is start plus line times pitch
// - Pitch low five bits forced zero
// - Pitch ignored when RGB output selected
// - Line index wraps after capacity value
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
module rsow_writer #(
    parameter int unsigned LINE_W = 13
) (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_arst_n,
    input  wire logic [rsow_pkg::ADDR_W-1:0]  i_avs_address,
    input  wire logic                         i_avs_read,
    input  wire logic                         i_avs_write,
    input  wire logic [31:0]                  i_avs_writedata,
    input  wire logic [3:0]                   i_avs_byteenable,
    output logic [31:0]                       o_avs_readdata,
    output logic                              o_avs_waitrequest,
    input  wire logic                         i_pix_valid,
    input  wire logic [7:0]                   i_pix_y,
    input  wire logic [7:0]                   i_pix_c,
    input  wire logic                         i_pix_sol,
    input  wire logic                         i_pix_eol,
    input  wire logic                         i_pix_eof,
    output logic                              o_pix_ready,
    output logic                              o_mem_write,
    output logic [31:0]                       o_mem_address,
    output logic [31:0]                       o_mem_writedata,
    output logic [3:0]                        o_mem_byteenable,
    input  wire logic                         i_mem_waitrequest
);
    import rsow_pkg::*;

    logic        dwn_en_r;
    logic [5:0]  dwn_av_r;
    logic        rgb_sel_r;
    logic [2:0]  rgb_fmt_r;
    logic [7:0]  alpha_r;
    logic [15:0] base_h_r, base_l_r, start_h_r, start_l_r, pitch_r;
    logic [12:0] ptr_s_r, ptr_e_r;
    logic        rd_ack_r;
    logic        wr_ack_r;

    // One wait state each way; a write lands only at the edge where waitrequest is seen low
    wire logic acc_wr = i_avs_write & ~wr_ack_r;
    wire logic wr_go  = i_avs_write & wr_ack_r;
    wire logic acc_rd = i_avs_read & ~rd_ack_r;
    assign o_avs_waitrequest = acc_wr | acc_rd;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ack_r <= 1'b0;
            rd_ack_r <= 1'b0;
        end else begin
            wr_ack_r <= acc_wr;
            rd_ack_r <= acc_rd;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dwn_en_r  <= 1'b0;
            dwn_av_r  <= 6'h00;
            rgb_sel_r <= 1'b0;
            rgb_fmt_r <= 3'h0;
            alpha_r   <= 8'h00;
            base_h_r  <= 16'h0000;
            base_l_r  <= 16'h0000;
            start_h_r <= 16'h0000;
            start_l_r <= 16'h0000;
            pitch_r   <= 16'h0000;
            ptr_s_r   <= 13'h0000;
            ptr_e_r   <= PTR_E_RESET;
        end else if (wr_go) begin
            unique case (i_avs_address)
                OFS_DWN_EN:  if (i_avs_byteenable[0]) dwn_en_r <= i_avs_writedata[0];
                OFS_DWN_AV:  if (i_avs_byteenable[0]) dwn_av_r <= i_avs_writedata[5:0];
                OFS_RGB_SEL: if (i_avs_byteenable[0]) rgb_sel_r <= i_avs_writedata[0];
                OFS_RGB_FMT: if (i_avs_byteenable[0]) rgb_fmt_r <= i_avs_writedata[2:0];
                OFS_ALPHA:   if (i_avs_byteenable[0]) alpha_r <= i_avs_writedata[7:0];
                OFS_BASE_H:  base_h_r  <= merge16(base_h_r, i_avs_writedata, i_avs_byteenable);
                OFS_BASE_L:  base_l_r  <= merge16(base_l_r, i_avs_writedata, i_avs_byteenable);
                OFS_START_H: start_h_r <= merge16(start_h_r, i_avs_writedata, i_avs_byteenable);
                OFS_START_L: start_l_r <= merge16(start_l_r, i_avs_writedata, i_avs_byteenable);
                OFS_PITCH:   pitch_r   <= merge16(pitch_r, i_avs_writedata, i_avs_byteenable);
                OFS_PTR_S:   ptr_s_r   <= 13'(merge16({3'h0, ptr_s_r}, i_avs_writedata, i_avs_byteenable));
                OFS_PTR_E:   ptr_e_r   <= 13'(merge16({3'h0, ptr_e_r}, i_avs_writedata, i_avs_byteenable));
                default: ;
            endcase
        end
    end

    // Effective address set
    wire logic [31:0] base_addr  = {base_h_r, base_l_r};
    wire logic [31:0] start_addr = {start_h_r, start_l_r};
    // Pitch: low bits forced zero; in RGB mode the pitch is the packed line length instead
    logic [15:0] pitch_eff;
    logic [15:0] rgb_line_bytes;

    // Line / pixel state
    logic [LINE_W-1:0] line_idx_r;
    logic [15:0]       pix_cnt_r;
    logic [15:0]       line_len_r;
    logic [31:0]       line_addr_r;
    logic [31:0]       wr_off_r;
    logic [7:0]        cb_hold_r;
    logic              cphase_r;

    always_comb begin
        rgb_line_bytes = rgb_fmt_r[FMT_WIDTH_SEL] ? 16'(line_len_r * RGB16_BYTES) : 16'(line_len_r * RGB32_BYTES);
        pitch_eff = {pitch_r[15:PITCH_ZERO_BITS], {PITCH_ZERO_BITS{1'b0}}};
        if (rgb_sel_r) pitch_eff = rgb_line_bytes;
    end

    // Down-scale averaging: accumulate 2^(h+1) pixels per output sample horizontally and
    // 2^(v+1) lines vertically via a line accumulator array.
    localparam int unsigned ACC_W  = 24;
    localparam int unsigned MAXW   = 256;
    logic [ACC_W-1:0] hacc_y_r, hacc_c_r;
    logic [8:0]       hcnt_r;
    logic [8:0]       vcnt_r;
    logic [7:0]       ocol_r;
    logic [ACC_W-1:0] vacc_y [MAXW];
    logic [ACC_W-1:0] vacc_c [MAXW];
    wire logic [3:0]  hsh = 4'(dwn_av_r[AVH_LSB +: 3]) + 4'h1;
    wire logic [3:0]  vsh = 4'(dwn_av_r[AVV_LSB +: 3]) + 4'h1;
    wire logic [8:0]  hlast = 9'((32'h1 << hsh) - 1);
    wire logic [8:0]  vlast = 9'((32'h1 << vsh) - 1);

    // Output pipe register
    logic        out_v_r;
    logic [7:0]  o_y_r, o_cb_r, o_cr_r, o_c_r;
    logic        out_eol_r;

    wire logic stall = o_mem_write & i_mem_waitrequest;
    assign o_pix_ready = ~stall;
    wire logic take = i_pix_valid & ~stall;

    wire logic [ACC_W-1:0] hsum_y = hacc_y_r + ACC_W'(i_pix_y);
    wire logic [ACC_W-1:0] hsum_c = hacc_c_r + ACC_W'(i_pix_c);
    wire logic h_done = (hcnt_r == hlast) | i_pix_eol;
    wire logic v_last = (vcnt_r == vlast);
    wire logic [ACC_W-1:0] vsum_y = ((vcnt_r == 9'h0) ? '0 : vacc_y[ocol_r]) + (hsum_y >> hsh);
    wire logic [ACC_W-1:0] vsum_c = ((vcnt_r == 9'h0) ? '0 : vacc_c[ocol_r]) + (hsum_c >> hsh);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hacc_y_r <= '0;
            hacc_c_r <= '0;
            hcnt_r   <= 9'h0;
            vcnt_r   <= 9'h0;
            ocol_r   <= 8'h0;
        end else if (take && dwn_en_r) begin
            if (h_done) begin
                hacc_y_r <= '0;
                hacc_c_r <= '0;
                hcnt_r   <= 9'h0;
                vacc_y[ocol_r] <= vsum_y;
                vacc_c[ocol_r] <= vsum_c;
                ocol_r <= i_pix_eol ? 8'h0 : ocol_r + 8'h1;
            end else begin
                hacc_y_r <= hsum_y;
                hacc_c_r <= hsum_c;
                hcnt_r   <= hcnt_r + 9'h1;
            end
            if (i_pix_eol) vcnt_r <= (v_last | i_pix_eof) ? 9'h0 : vcnt_r + 9'h1;
        end
    end

    // Sample stream after optional averaging; YCbCr 4:2:2 chroma alternates Cb, Cr
    logic       s_v;
    logic [7:0] s_y, s_c;
    always_comb begin
        s_v = take;
        s_y = i_pix_y;
        s_c = i_pix_c;
        if (dwn_en_r) begin
            s_v = take & h_done & v_last;
            s_y = 8'(vsum_y >> vsh);
            s_c = 8'(vsum_c >> vsh);
        end
    end

    // 4:2:2 to 4:4:4 by holding Cb and pairing with following Cr
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cphase_r  <= 1'b0;
            cb_hold_r <= 8'h80;
            out_v_r   <= 1'b0;
            o_y_r     <= 8'h00;
            o_cb_r    <= 8'h80;
            o_cr_r    <= 8'h80;
            o_c_r     <= 8'h80;
            out_eol_r <= 1'b0;
        end else if (!stall) begin
            out_v_r <= s_v;
            out_eol_r <= s_v & i_pix_eol;
            if (s_v) begin
                o_c_r  <= s_c;
                cphase_r <= i_pix_eol ? 1'b0 : ~cphase_r;
                if (!cphase_r) cb_hold_r <= s_c;
                o_y_r  <= s_y;
                o_cb_r <= cphase_r ? cb_hold_r : s_c;
                o_cr_r <= cphase_r ? s_c : cb_hold_r;
            end
        end
    end

    // YCbCr to RGB (BT.601 integer approximation), clamped then truncated
    function automatic logic [7:0] clamp8(input logic signed [17:0] v);
        clamp8 = (v < 0) ? 8'h00 : (v > 18'sd255) ? 8'hff : v[7:0];
    endfunction
    logic signed [17:0] cy, cu, cv;
    logic [7:0] r8, g8, b8;
    always_comb begin
        cy = 18'(o_y_r);
        cu = 18'(o_cb_r) - 18'sd128;
        cv = 18'(o_cr_r) - 18'sd128;
        r8 = clamp8(cy + ((18'sd359 * cv) >>> 8));
        g8 = clamp8(cy - ((18'sd88 * cu + 18'sd183 * cv) >>> 8));
        b8 = clamp8(cy + ((18'sd454 * cu) >>> 8));
    end

    // Masking of boundary pixels on the written stream
    wire logic msk_lead  = rgb_fmt_r[FMT_LEAD_MASK] & (pix_cnt_r < 16'(MASK_PIX));
    wire logic msk_trail = rgb_fmt_r[FMT_TRAIL_MASK] & (line_len_r >= 16'(MASK_PIX)) &
                           (pix_cnt_r >= line_len_r - 16'(MASK_PIX));
    // Line length is learned from the previous line; the trailing mask relies on equal lines
    logic [31:0] pix_word;
    logic [3:0]  pix_be;
    logic [31:0] pix_bytes;
    always_comb begin
        pix_bytes = 32'(YC_BYTES);
        // 4:2:2 words keep the sample's own chroma, so Cb and Cr alternate as they came in
        pix_word  = {16'h0000, o_c_r, o_y_r};
        pix_be    = 4'h3;
        if (rgb_sel_r) begin
            if (rgb_fmt_r[FMT_WIDTH_SEL]) begin
                pix_bytes = 32'(RGB16_BYTES);
                pix_word  = {16'h0000, r8[7:3], g8[7:2], b8[7:3]};
            end else begin
                pix_bytes = 32'(RGB32_BYTES);
                pix_word  = {alpha_r, r8, g8, b8};
                pix_be    = 4'hf;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mem_write      <= 1'b0;
            o_mem_address    <= 32'h0;
            o_mem_writedata  <= 32'h0;
            o_mem_byteenable <= 4'h0;
        end else if (!stall) begin
            o_mem_write      <= out_v_r & ~msk_lead & ~msk_trail;
            o_mem_address    <= line_addr_r + wr_off_r;
            o_mem_writedata  <= pix_word;
            o_mem_byteenable <= pix_be;
        end
    end

    // Line pointer walks from start line pointer; wraps to line 0 after capacity value
    wire logic eol_out = out_v_r & ~stall & out_eol_r;
    logic eol_seen_r;
    // Frame opens at its first start-of-line; later lines follow the pointer chain until end-of-frame
    wire logic frame_go = i_pix_valid & i_pix_sol & ~stall & (pix_cnt_r == 16'h0) & ~eol_seen_r;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            eol_seen_r <= 1'b0;
        end else if (i_pix_valid & i_pix_eof & ~stall) begin
            eol_seen_r <= 1'b0;
        end else if (frame_go) begin
            eol_seen_r <= 1'b1;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            line_idx_r  <= '0;
            line_addr_r <= 32'h0;
            pix_cnt_r   <= 16'h0;
            wr_off_r    <= 32'h0;
        end else if (frame_go) begin
            line_idx_r  <= LINE_W'(ptr_s_r);
            line_addr_r <= start_addr + 32'(ptr_s_r) * 32'(pitch_eff);
        end else if (out_v_r & ~stall) begin
            wr_off_r  <= wr_off_r + pix_bytes;
            pix_cnt_r <= pix_cnt_r + 16'h1;
            if (eol_out) begin
                pix_cnt_r <= 16'h0;
                wr_off_r  <= 32'h0;
                if (line_idx_r >= LINE_W'(ptr_e_r)) begin
                    line_idx_r  <= '0;
                    line_addr_r <= start_addr;
                end else begin
                    line_idx_r  <= line_idx_r + 1'b1;
                    line_addr_r <= line_addr_r + 32'(pitch_eff);
                end
            end
        end
    end

    // Line length register: counts input-domain outputs per line for trailing mask
    logic [15:0] len_cnt_r;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            len_cnt_r  <= 16'h0;
            line_len_r <= 16'hffff;
        end else if (s_v) begin
            len_cnt_r <= i_pix_eol ? 16'h0 : len_cnt_r + 16'h1;
            if (i_pix_eol) line_len_r <= len_cnt_r + 16'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_avs_readdata <= 32'h0;
        end else if (acc_rd) begin
            unique case (i_avs_address)
                OFS_DWN_EN:  o_avs_readdata <= {31'h0, dwn_en_r};
                OFS_DWN_AV:  o_avs_readdata <= {26'h0, dwn_av_r};
                OFS_RGB_SEL: o_avs_readdata <= {31'h0, rgb_sel_r};
                OFS_RGB_FMT: o_avs_readdata <= {29'h0, rgb_fmt_r};
                OFS_ALPHA:   o_avs_readdata <= {24'h0, alpha_r};
                OFS_BASE_H:  o_avs_readdata <= {16'h0, base_h_r};
                OFS_BASE_L:  o_avs_readdata <= {16'h0, base_l_r};
                OFS_START_H: o_avs_readdata <= {16'h0, start_h_r};
                OFS_START_L: o_avs_readdata <= {16'h0, start_l_r};
                OFS_PITCH:   o_avs_readdata <= {16'h0, pitch_r};
                OFS_PTR_S:   o_avs_readdata <= {19'h0, ptr_s_r};
                OFS_PTR_E:   o_avs_readdata <= {19'h0, ptr_e_r};
                OFS_STATUS:  o_avs_readdata <= {16'h0, 3'h0, 13'(line_idx_r)};
                default:     o_avs_readdata <= RSV_VALUE;
            endcase
        end
    end

    a_wait_one: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_avs_write & o_avs_waitrequest) |=> !o_avs_waitrequest) else $error("write wait too long");
    a_lead_mask: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (out_v_r & !stall & rgb_fmt_r[FMT_LEAD_MASK] & pix_cnt_r == 16'h0) |=> !o_mem_write)
        else $error("leading pixel written");
    a_alpha_fill: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (o_mem_write & rgb_sel_r & !rgb_fmt_r[FMT_WIDTH_SEL] & $stable(alpha_r) & $stable(rgb_sel_r))
        |-> o_mem_writedata[31:24] == alpha_r)
        else $error("alpha byte wrong");
    a_pitch_low: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !rgb_sel_r |-> pitch_eff[4:0] == 5'h0)
        else $error("pitch low bits set");
    a_line_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (eol_out & line_idx_r >= LINE_W'(ptr_e_r)) |=> line_idx_r == '0)
        else $error("line index did not wrap");
    a_bypass_avg: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (!dwn_en_r & take) |-> s_v)
        else $error("bypass lost a pixel");
    a_rgb565_pack: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (o_mem_write & rgb_sel_r & rgb_fmt_r[FMT_WIDTH_SEL] & $stable(rgb_fmt_r)) |-> o_mem_writedata[31:16] == 16'h0)
        else $error("rgb565 upper half set");
    a_ycc_select: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (o_mem_write & !rgb_sel_r & $stable(rgb_sel_r)) |-> o_mem_byteenable == 4'h3)
        else $error("ycc lanes wrong");
    c_rgb32: cover property (@(posedge i_clk_sys) o_mem_write & rgb_sel_r & !rgb_fmt_r[FMT_WIDTH_SEL]);
    c_wrap: cover property (@(posedge i_clk_sys) eol_out & line_idx_r >= LINE_W'(ptr_e_r));
    c_avg: cover property (@(posedge i_clk_sys) dwn_en_r & s_v);
endmodule

// file: verilog/rsow_pkg.sv
// Purpose: Constants shared by the resizer output writer
// Assumes: Avalon-MM register map of 32-bit words
// Notes:   Register offsets are byte addresses
package rsow_pkg;
    localparam int unsigned ADDR_W          = 6;
    localparam logic [5:0] OFS_DWN_EN       = 6'h00;
    localparam logic [5:0] OFS_DWN_AV       = 6'h04;
    localparam logic [5:0] OFS_RGB_SEL      = 6'h08;
    localparam logic [5:0] OFS_RGB_FMT      = 6'h0c;
    localparam logic [5:0] OFS_ALPHA        = 6'h10;
    localparam logic [5:0] OFS_BASE_H       = 6'h14;
    localparam logic [5:0] OFS_BASE_L       = 6'h18;
    localparam logic [5:0] OFS_START_H      = 6'h1c;
    localparam logic [5:0] OFS_START_L      = 6'h20;
    localparam logic [5:0] OFS_PITCH        = 6'h24;
    localparam logic [5:0] OFS_PTR_S        = 6'h28;
    localparam logic [5:0] OFS_PTR_E        = 6'h2c;
    localparam logic [5:0] OFS_STATUS       = 6'h30;
    localparam int unsigned AVH_LSB         = 0;
    localparam int unsigned AVV_LSB         = 3;
    localparam int unsigned FMT_WIDTH_SEL   = 0;
    localparam int unsigned FMT_LEAD_MASK   = 1;
    localparam int unsigned FMT_TRAIL_MASK  = 2;
    localparam int unsigned MASK_PIX        = 2;
    localparam int unsigned PITCH_ZERO_BITS = 5;
    localparam logic [12:0] PTR_E_RESET     = 13'h1fff;
    localparam logic [31:0] RSV_VALUE       = 32'h0000_0000;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned PIX_W           = 32;
    localparam int unsigned RGB32_BYTES     = 4;
    localparam int unsigned RGB16_BYTES     = 2;
    localparam int unsigned YC_BYTES        = 2;
endpackage

// file: bench/rsow_mem_model.sv
// Purpose: SDRAM write port model for the resizer output writer bench
// Assumes: Write-only Avalon-MM slave, one word taken per accepted write
// Notes:   Slow mode stalls two of every four cycles to exercise held outputs
`timescale 1ns/1ps
module rsow_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    input  wire logic        i_slow,
    input  wire logic        i_mem_write,
    input  wire logic [31:0] i_mem_address,
    input  wire logic [31:0] i_mem_writedata,
    input  wire logic [3:0]  i_mem_byteenable,
    output logic             o_mem_waitrequest
);
    logic [31:0] addr_q[$];
    logic [31:0] data_q[$];
    logic [3:0]  be_q[$];
    logic [1:0]  stall_r;
    assign o_mem_waitrequest = i_slow & ~stall_r[1];
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stall_r <= 2'h0;
        end else begin
            stall_r <= stall_r + 2'h1;
            if (i_mem_write && !o_mem_waitrequest) begin
                addr_q.push_back(i_mem_address);
                data_q.push_back(i_mem_writedata);
                be_q.push_back(i_mem_byteenable);
            end
        end
    end
endmodule

// file: bench/rsow_writer_test.sv
// Purpose: Self-checking bench for the resizer output writer
// Assumes: One memory write per output pixel; reserved register bits read 0
// Notes:   Line placement judged from the first write recorded for each line
`timescale 1ns/1ps
module rsow_writer_test;
    import rsow_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, slow = 1'b0;
    logic        pv = 1'b0, sol = 1'b0, eol = 1'b0, eof = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wdat = 32'h0, rdat, avs_rdata, mem_addr, mem_data;
    logic [7:0]  py = 8'h00, pc = 8'h80;
    logic [3:0]  mem_be;
    logic        avs_wait, pix_rdy, mem_wr, mem_wait;
    int          error_cnt = 0, samples_checked = 0;
    int          mark[8];
    logic [5:0]  ofs_t[10] = '{OFS_DWN_EN, OFS_DWN_AV, OFS_RGB_SEL, OFS_RGB_FMT, OFS_ALPHA,
                               OFS_BASE_H, OFS_BASE_L, OFS_START_H, OFS_START_L, OFS_PTR_S};
    logic [31:0] msk_t[10] = '{32'h1, 32'h3f, 32'h1, 32'h7, 32'hff, 32'hffff, 32'hffff,
                               32'hffff, 32'hffff, 32'h1fff};
    logic [31:0] av_t[4] = '{32'h00, 32'h01, 32'h02, 32'h08};
    int          ln_t[4] = '{2, 2, 2, 4};
    int          ex_t[4] = '{8, 4, 2, 8};

    rsow_writer u_rsow_writer (.i_clk_sys(clk), .i_arst_n(arst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf), .o_avs_readdata(avs_rdata),
        .o_avs_waitrequest(avs_wait), .i_pix_valid(pv), .i_pix_y(py), .i_pix_c(pc), .i_pix_sol(sol),
        .i_pix_eol(eol), .i_pix_eof(eof), .o_pix_ready(pix_rdy), .o_mem_write(mem_wr),
        .o_mem_address(mem_addr), .o_mem_writedata(mem_data), .o_mem_byteenable(mem_be),
        .i_mem_waitrequest(mem_wait));
    rsow_mem_model u_rsow_mem_model (.i_clk_sys(clk), .i_arst_n(arst_n), .i_slow(slow),
        .i_mem_write(mem_wr), .i_mem_address(mem_addr), .i_mem_writedata(mem_data), .i_mem_byteenable(mem_be),
        .o_mem_waitrequest(mem_wait));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task automatic reg_acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= ~w;
        do @(posedge clk); while (avs_wait !== 1'b0);
        rdat = avs_rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic pix_line(input int n, input logic last);
        @(posedge clk);
        for (int k = 0; k < n; k++) begin
            py <= 8'(16 * k);
            pc <= (k % 2 == 0) ? 8'h70 : 8'h90;
            pv <= 1'b1;
            sol <= (k == 0);
            eol <= (k == n - 1);
            eof <= last && (k == n - 1);
            do @(posedge clk); while (pix_rdy !== 1'b1);
        end
        pv <= 1'b0;
    endtask

    task automatic frame(input int lines, input int n);
        for (int l = 0; l < lines; l++) begin
            mark[l] = u_rsow_mem_model.addr_q.size();
            pix_line(n, l == lines - 1);
            repeat (16) @(posedge clk);
        end
        mark[lines] = u_rsow_mem_model.addr_q.size();
    endtask

    function automatic logic [31:0] qa(input int i);
        return u_rsow_mem_model.addr_q[i];
    endfunction

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            reg_acc(1'b0, 6'(4 * i), 32'h0);
            chk("reset value", (i == 11) ? 32'h0000_1fff : 32'h0, rdat);
        end
        for (int i = 0; i < 10; i++) begin
            reg_acc(1'b1, ofs_t[i], 32'hffff_ffff);
            reg_acc(1'b0, ofs_t[i], 32'h0);
            chk("field width", msk_t[i], rdat);
            reg_acc(1'b1, ofs_t[i], 32'h0);
        end
        reg_acc(1'b1, 6'h38, 32'hffff_ffff);
        reg_acc(1'b0, 6'h38, 32'h0);
        chk("unmapped", 32'h0, rdat);
        // Start equals base; start line pointer was cleared above, so the first line lands at start
        reg_acc(1'b1, OFS_BASE_H, 32'h0010);
        reg_acc(1'b1, OFS_BASE_L, 32'h0100);
        reg_acc(1'b1, OFS_START_H, 32'h0010);
        reg_acc(1'b1, OFS_START_L, 32'h0100);
        reg_acc(1'b1, OFS_PITCH, 32'h0047);
        reg_acc(1'b1, OFS_PTR_E, 32'h0001);
        slow <= 1'b1;
        frame(3, 4);
        for (int l = 0; l < 3; l++) begin
            chk("yc line addr", 32'h0010_0100 + 32'((l % 2) * 32'h40), qa(mark[l]));
            chk("yc writes", 32'd4, 32'(mark[l + 1] - mark[l]));
        end
        chk("yc step", 32'(YC_BYTES), qa(mark[0] + 1) - qa(mark[0]));
        chk("yc data", 32'h0000_9010, u_rsow_mem_model.data_q[mark[0] + 1]);
        chk("yc lanes", 32'h3, 32'(u_rsow_mem_model.be_q[mark[0]]));
        reg_acc(1'b1, OFS_PTR_S, 32'h0001);
        frame(1, 4);
        chk("first line ptr", 32'h0010_0140, qa(mark[0]));
        // RGB mode: pointers multiple of four, programmed pitch must be ignored
        reg_acc(1'b1, OFS_PTR_S, 32'h0000);
        reg_acc(1'b1, OFS_PTR_E, 32'h0004);
        reg_acc(1'b1, OFS_PITCH, 32'h1000);
        reg_acc(1'b1, OFS_RGB_SEL, 32'h1);
        reg_acc(1'b1, OFS_ALPHA, 32'h00a5);
        frame(2, 8);
        chk("rgb line 1", 32'h0010_0100 + 32'(8 * RGB32_BYTES), qa(mark[1]));
        chk("rgb32 step", 32'(RGB32_BYTES), qa(mark[0] + 1) - qa(mark[0]));
        chk("rgb32 lanes", 32'hf, 32'(u_rsow_mem_model.be_q[mark[0]]));
        for (int i = mark[0]; i < mark[2]; i++) begin
            chk("alpha byte", 32'ha5, 32'(u_rsow_mem_model.data_q[i][31:24]));
        end
        reg_acc(1'b1, OFS_RGB_FMT, 32'h3);
        frame(1, 8);
        chk("lead mask writes", 32'd6, 32'(mark[1] - mark[0]));
        chk("lead mask addr", 32'h0010_0104, qa(mark[0]));
        chk("rgb16 step", 32'(RGB16_BYTES), qa(mark[0] + 1) - qa(mark[0]));
        chk("rgb16 lanes", 32'h3, 32'(u_rsow_mem_model.be_q[mark[0]]));
        chk("rgb16 upper", 32'h0, 32'(u_rsow_mem_model.data_q[mark[0]][31:16]));
        reg_acc(1'b1, OFS_RGB_FMT, 32'h5);
        frame(1, 8);
        chk("trail mask writes", 32'd6, 32'(mark[1] - mark[0]));
        chk("trail mask addr", 32'h0010_0100, qa(mark[0]));
        reg_acc(1'b1, OFS_RGB_FMT, 32'h0);
        reg_acc(1'b1, OFS_RGB_SEL, 32'h0);
        reg_acc(1'b1, OFS_DWN_EN, 32'h1);
        // Horizontal code stepped 0 to 2 while vertical code is 0, then vertical code 1 with horizontal code 0
        for (int i = 0; i < 4; i++) begin
            reg_acc(1'b1, OFS_DWN_AV, av_t[i]);
            frame(ln_t[i], 16);
            chk("average writes", 32'(ex_t[i]), 32'(mark[ln_t[i]] - mark[0]));
        end
        end_sim();
    end

    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
endmodule
